// *** design/qlpd_defs.vh ***
// constants for the quadrature local oscillator phase divider
`ifndef QLPD_DEFS_VH
`define QLPD_DEFS_VH

// register map
`define QLPD_REG_PHASE_SEL 8'h2d
`define QLPD_PHASE_SEL_RST 8'h00
`define QLPD_CODE_MSB 3
`define QLPD_CODE_LSB 0
`define QLPD_EN_BIT 4
`define QLPD_REG_USED_MSB 4

// channel count and coefficient width
`define QLPD_NUM_CHAN 8
`define QLPD_COEF_W 8

// divider states: count value, I high for 0..1, Q high for 1..2
`define QLPD_DIV_HOLD 2'h3
`define QLPD_DIV_PWRUP 2'h0
`define QLPD_DIV_LAST 2'h3

// timing of the array sync pulse
`define QLPD_CLK_PERIOD_NS 20
`define QLPD_SYNC_MIN_NS 20

`endif

// *** design/qlpd_chan_rot.v ***
// one channel: phase select register, enable and rotation coefficients
`include "qlpd_defs.vh"

module qlpd_chan_rot
(
   input wire clk,
   input wire reset,
   input wire wr_en,
   input wire [7:0] wdata,
   input wire apply,
   output wire [7:0] reg_value,
   output reg enable_reg,
   output reg [3:0] code_reg,
   output reg [7:0] cos_reg,
   output reg [7:0] sin_reg
);

   reg [7:0] sel_reg;
   wire [3:0] new_code;
   wire new_enable;

   // signed cosine of n times 22.5 degrees, scaled to 127
   function [7:0] cos_lut;
      input [3:0] idx;
      begin
         case (idx)
            4'h0: cos_lut = 8'h7f;
            4'h1: cos_lut = 8'h75;
            4'h2: cos_lut = 8'h5a;
            4'h3: cos_lut = 8'h31;
            4'h4: cos_lut = 8'h00;
            4'h5: cos_lut = 8'hcf;
            4'h6: cos_lut = 8'ha6;
            4'h7: cos_lut = 8'h8b;
            4'h8: cos_lut = 8'h81;
            4'h9: cos_lut = 8'h8b;
            4'ha: cos_lut = 8'ha6;
            4'hb: cos_lut = 8'hcf;
            4'hc: cos_lut = 8'h00;
            4'hd: cos_lut = 8'h31;
            4'he: cos_lut = 8'h5a;
            default: cos_lut = 8'h75;
         endcase
      end
   endfunction

   // each channel keeps its own copy, unused bits read zero
   always @(posedge clk)
   begin
      if (reset)
         sel_reg <= `QLPD_PHASE_SEL_RST;
      else if (wr_en)
         sel_reg <= {3'h0, wdata[`QLPD_REG_USED_MSB:0]}; // RL13
   end

   assign reg_value = sel_reg;
   assign new_code = sel_reg[`QLPD_CODE_MSB:`QLPD_CODE_LSB];
   assign new_enable = sel_reg[`QLPD_EN_BIT];

   // staged to an lo period boundary while running, so the step is whole, never partial
   always @(posedge clk)
   begin
      if (reset)
      begin
         enable_reg <= 1'b0;
         code_reg <= 4'h0;
         cos_reg <= 8'h00;
         sin_reg <= 8'h00;
      end
      else if (apply)
      begin
         enable_reg <= new_enable; // RL12
         code_reg <= new_code; // RL14
         // positive angle: higher code leads, equal codes match
         cos_reg <= new_enable ? cos_lut(new_code) : 8'h00; // RL6 RL7 RL8
         sin_reg <= new_enable ? cos_lut(new_code - 4'h4) : 8'h00; // RL6
      end
   end

endmodule // qlpd_chan_rot

// *** design/qlpd_phase_divider.v ***
// quadrature lo divider with array sync and per-channel phase rotation
//
// Behaviour
// RL1: divide 4x lo clock by four, I/Q
// RL2: both lo outputs exactly 50 percent duty
// RL3: lo outputs retimed on 4x clock edges
// RL4: sync pin forces divider to known state
// RL5: system drives one common sync pulse
// RL6: 4-bit code rotates by n*22.5 degrees
// RL7: higher code leads by 22.5 degrees
// RL8: equal codes give in-phase outputs
// RL9: unsynced divider may start in any phase
// RL10: sync active high, held 20 ns minimum
// RL11: divider restarts on next 4x rising edge
// RL12: channel runs only when enable bit set
// RL13: each channel holds its own code
// RL14: code changes step whole, no intermediate
`include "qlpd_defs.vh"

module qlpd_phase_divider
#(
   parameter NUM_CHAN = `QLPD_NUM_CHAN,
   parameter [1:0] PWRUP_PHASE = `QLPD_DIV_PWRUP
)
(
   input wire clk,
   input wire reset,
   input wire lo_quad_rate_clock_in,
   input wire array_sync_in,
   input wire cfg_wr,
   input wire cfg_rd,
   input wire [7:0] cfg_addr,
   input wire [NUM_CHAN-1:0] cfg_chan_mask,
   input wire [2:0] cfg_rd_chan,
   input wire [7:0] cfg_wdata,
   output reg [7:0] cfg_rdata_reg,
   output reg cfg_rvalid_reg,
   output reg lo_i_reg,
   output reg lo_q_reg,
   output reg [1:0] lo_phase_reg,
   output reg divider_run_reg,
   output wire [NUM_CHAN-1:0] chan_enable,
   output wire [4*NUM_CHAN-1:0] chan_code,
   output wire [8*NUM_CHAN-1:0] chan_cos,
   output wire [8*NUM_CHAN-1:0] chan_sin
);

   // sync pulse length in clock cycles, rounded up, at least one
   localparam SYNC_MIN_CYC_RAW =
      (`QLPD_SYNC_MIN_NS + `QLPD_CLK_PERIOD_NS - 1) / `QLPD_CLK_PERIOD_NS;
   localparam SYNC_MIN_CYC = (SYNC_MIN_CYC_RAW < 1) ? 1 : SYNC_MIN_CYC_RAW;

   // divider states, one-hot
   localparam [2:0] ST_FREE = 3'h1;
   localparam [2:0] ST_HOLD = 3'h2;
   localparam [2:0] ST_ARM = 3'h4;

   reg [2:0] lo_sync_reg;
   reg lo_level_reg;
   reg [2:0] rst_sync_reg;
   reg rst_level_reg;
   reg [3:0] sync_len_reg;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [1:0] cnt_reg;
   reg [1:0] cnt_next;
   wire lo_rise;
   wire sync_valid;
   wire lo_wrap;
   wire apply;
   wire addr_hit;
   wire [8*NUM_CHAN-1:0] reg_values;

   // three stages per pin; a change counts once stages two and three agree
   always @(posedge clk)
   begin
      if (reset)
      begin
         lo_sync_reg <= 3'h0;
         rst_sync_reg <= 3'h0;
      end
      else
      begin
         lo_sync_reg <= {lo_sync_reg[1:0], lo_quad_rate_clock_in};
         rst_sync_reg <= {rst_sync_reg[1:0], array_sync_in};
      end
   end

   // qualified levels, updated only from agreeing later stages
   always @(posedge clk)
   begin
      if (reset)
      begin
         lo_level_reg <= 1'b0;
         rst_level_reg <= 1'b0;
      end
      else
      begin
         if (lo_sync_reg[1] == lo_sync_reg[2])
            lo_level_reg <= lo_sync_reg[2];
         if (rst_sync_reg[1] == rst_sync_reg[2])
            rst_level_reg <= rst_sync_reg[2];
      end
   end

   // rising edge of the 4x clock acts as the divider's clock enable
   assign lo_rise = (lo_sync_reg[1] == lo_sync_reg[2]) && lo_sync_reg[2] && !lo_level_reg; // RL3

   // count how long the sync pin has been high; saturates
   always @(posedge clk)
   begin
      if (reset)
         sync_len_reg <= 4'h0;
      else if (!rst_level_reg)
         sync_len_reg <= 4'h0;
      else if (sync_len_reg != 4'hf)
         sync_len_reg <= sync_len_reg + 4'h1;
   end

   // pulse may rise at any time; accepted once long enough
   assign sync_valid = rst_level_reg && (sync_len_reg >= SYNC_MIN_CYC[3:0] - 4'h1); // RL10

   // divider sequencing
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_FREE:
         begin
            if (sync_valid)
               state_next = ST_HOLD; // RL4
         end
         ST_HOLD:
         begin
            if (!rst_level_reg)
               state_next = ST_ARM;
         end
         ST_ARM:
         begin
            if (sync_valid)
               state_next = ST_HOLD;
            else if (lo_rise)
               state_next = ST_FREE; // RL11
         end
         default:
            state_next = ST_HOLD;
      endcase
   end

   // count value: held in a known state, else one step per 4x rising edge
   always @*
   begin
      cnt_next = cnt_reg;
      if (state_next == ST_HOLD)
         cnt_next = `QLPD_DIV_HOLD; // RL4
      else if (lo_rise && state_reg != ST_HOLD)
         cnt_next = cnt_reg + 2'h1; // RL1
   end

   // power-up phase is arbitrary relative to other devices until synced
   always @(posedge clk)
   begin
      if (reset)
      begin
         state_reg <= ST_FREE;
         cnt_reg <= `QLPD_DIV_PWRUP;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= (state_reg == ST_FREE && state_next == ST_FREE && !lo_rise &&
            divider_run_reg == 1'b0) ? PWRUP_PHASE : cnt_next; // RL9
      end
   end

   // outputs decoded from the next count and registered, so each edge
   // lines up with a 4x edge and each level lasts two 4x periods
   always @(posedge clk)
   begin
      if (reset)
      begin
         lo_i_reg <= 1'b0;
         lo_q_reg <= 1'b0;
         lo_phase_reg <= 2'h0;
         divider_run_reg <= 1'b0;
      end
      else
      begin
         lo_i_reg <= (state_next != ST_HOLD) && !cnt_next[1]; // RL1 RL2 RL3
         lo_q_reg <= (state_next != ST_HOLD) && (cnt_next[1] ^ cnt_next[0]); // RL1 RL2
         lo_phase_reg <= cnt_next;
         divider_run_reg <= (state_next == ST_FREE) && (divider_run_reg || lo_rise);
      end
   end

   // code changes land at the end of a whole lo period, or at once when held
   assign lo_wrap = lo_rise && (cnt_reg == `QLPD_DIV_LAST);
   assign apply = lo_wrap || (state_reg != ST_FREE) || !divider_run_reg; // RL14

   assign addr_hit = (cfg_addr == `QLPD_REG_PHASE_SEL);

   // one register per channel, written through the channel mask
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHAN; gi = gi + 1)
      begin : g_chan
         qlpd_chan_rot u_rot
         (
            .clk(clk),
            .reset(reset),
            .wr_en(cfg_wr && addr_hit && cfg_chan_mask[gi]), // RL13
            .wdata(cfg_wdata),
            .apply(apply),
            .reg_value(reg_values[8*gi +: 8]),
            .enable_reg(chan_enable[gi]),
            .code_reg(chan_code[4*gi +: 4]),
            .cos_reg(chan_cos[8*gi +: 8]),
            .sin_reg(chan_sin[8*gi +: 8])
         );
      end
   endgenerate

   // read answer one cycle later; unmapped address reads zero
   always @(posedge clk)
   begin
      if (reset)
      begin
         cfg_rdata_reg <= 8'h00;
         cfg_rvalid_reg <= 1'b0;
      end
      else
      begin
         cfg_rvalid_reg <= cfg_rd;
         if (cfg_rd)
            cfg_rdata_reg <= (addr_hit && cfg_rd_chan < NUM_CHAN) ?
               reg_values[8*cfg_rd_chan +: 8] : 8'h00;
      end
   end

   // all devices in an array share one sync pulse; nothing here can
   // align a device whose pin was not driven with the rest (RL5)

endmodule // qlpd_phase_divider

// *** sim/qlpd_quad_src.sv ***
// partner model: 4x clock source and array sync driver
module qlpd_quad_src
(
   input wire clk,
   input wire run,
   input wire sync_req,
   output logic quad_clk,
   output logic sync_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt;
   initial
   begin
      cnt = 4'h0;
      quad_clk = 1'b0;
      sync_pin = 1'b0;
   end
   // ten clk per 4x period, so each level lasts five clk cycles
   always @(negedge clk)
   begin
      if (run)
      begin
         cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
         quad_clk <= (cnt < 4'h5);
      end
      // with run high, sync moves only on a 4x falling edge: full setup, width of whole periods
      if (!run || (quad_clk && cnt == 4'h5))
         sync_pin <= sync_req;
   end
endmodule // qlpd_quad_src

// *** sim/qlpd_monitor.sv ***
// assertion checker bound to the phase divider ports
module qlpd_monitor
(
   input wire clk,
   input wire reset,
   input wire array_sync_in,
   input wire cfg_rd,
   input wire [7:0] cfg_addr,
   input wire [7:0] cfg_rdata_reg,
   input wire cfg_rvalid_reg,
   input wire lo_i_reg,
   input wire lo_q_reg,
   input wire [1:0] lo_phase_reg,
   input wire divider_run_reg
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   AST_RVALID:
      assert property (cfg_rd |=> cfg_rvalid_reg) else $error("read not answered");
   AST_NOVALID:
      assert property (!cfg_rd |=> !cfg_rvalid_reg) else $error("stray read valid");
   AST_UNMAP:
      assert property (cfg_rd && cfg_addr != 8'h2d |=> cfg_rdata_reg == 8'h00)
         else $error("unmapped read not zero");
   AST_I_DUTY:
      assert property (divider_run_reg |-> lo_i_reg == (lo_phase_reg < 2'h2))
         else $error("in-phase output wrong for count");
   AST_Q_DUTY:
      assert property (divider_run_reg |-> lo_q_reg == (lo_phase_reg inside {2'h1, 2'h2}))
         else $error("quadrature output wrong for count");
   AST_STEP:
      assert property (divider_run_reg && $past(divider_run_reg) && $changed(lo_phase_reg)
         |-> lo_phase_reg == $past(lo_phase_reg) + 2'h1) else $error("count skipped");
   AST_HOLD:
      assert property (array_sync_in [*5] |=> !lo_i_reg && !lo_q_reg && !divider_run_reg
         && lo_phase_reg == 2'h3) else $error("sync did not hold divider");
   AST_STOP:
      assert property ($fell(divider_run_reg) |-> $past(array_sync_in, 3)
         || $past(array_sync_in, 4) || $past(array_sync_in, 5)) else $error("stop without sync");
   AST_RESTART:
      assert property ($rose(divider_run_reg) && $past(lo_phase_reg) == 2'h3
         |-> lo_i_reg && !lo_q_reg && lo_phase_reg == 2'h0) else $error("bad restart state");
endmodule // qlpd_monitor

bind qlpd_phase_divider qlpd_monitor u_mon (.clk(clk), .reset(reset),
   .array_sync_in(array_sync_in), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
   .cfg_rdata_reg(cfg_rdata_reg), .cfg_rvalid_reg(cfg_rvalid_reg), .lo_i_reg(lo_i_reg),
   .lo_q_reg(lo_q_reg), .lo_phase_reg(lo_phase_reg), .divider_run_reg(divider_run_reg));

// *** sim/tb_qlpd_phase_divider.sv ***
// self-checking bench for the phase divider
module tb_qlpd_phase_divider;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, reset = 1, clk_run = 0, sync_req = 0, cfg_wr = 0, cfg_rd = 0;
   logic [7:0] cfg_addr = 8'h2d, cfg_chan_mask = 8'h00, cfg_wdata = 8'h00;
   logic [2:0] cfg_rd_chan = 3'h0;
   wire quad_clk, sync_pin, cfg_rvalid_reg, lo_i_reg, lo_q_reg, divider_run_reg;
   wire [7:0] cfg_rdata_reg, chan_enable;
   wire [1:0] lo_phase_reg;
   wire [31:0] chan_code;
   wire [63:0] chan_cos, chan_sin;
   logic [15:0] tbl [4] = '{16'h7f00, 16'h007f, 16'h8100, 16'h0081};
   int err_total = 0, num_checks = 0, n, hi_i, hi_q;
   qlpd_quad_src u_src (.clk(clk), .run(clk_run), .sync_req(sync_req), .quad_clk(quad_clk),
      .sync_pin(sync_pin));
   qlpd_phase_divider dut (.clk(clk), .reset(reset), .lo_quad_rate_clock_in(quad_clk),
      .array_sync_in(sync_pin), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
      .cfg_chan_mask(cfg_chan_mask), .cfg_rd_chan(cfg_rd_chan), .cfg_wdata(cfg_wdata),
      .cfg_rdata_reg(cfg_rdata_reg), .cfg_rvalid_reg(cfg_rvalid_reg), .lo_i_reg(lo_i_reg),
      .lo_q_reg(lo_q_reg), .lo_phase_reg(lo_phase_reg), .divider_run_reg(divider_run_reg),
      .chan_enable(chan_enable), .chan_code(chan_code), .chan_cos(chan_cos),
      .chan_sin(chan_sin));
   initial
   begin
      forever #10 clk = ~clk;
   end
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one-cycle strobes, set and dropped on falling edges
   task wr(input logic [7:0] m, input logic [7:0] d);
      cfg_chan_mask = m;
      cfg_wdata = d;
      cfg_wr = 1;
      @(negedge clk);
      cfg_wr = 0;
      @(negedge clk);
   endtask
   task rd(input logic [2:0] c, input logic [7:0] a, input logic [7:0] e);
      cfg_rd_chan = c;
      cfg_addr = a;
      cfg_rd = 1;
      @(negedge clk);
      cfg_rd = 0;
      cfg_addr = 8'h2d;
      chk({cfg_rvalid_reg, cfg_rdata_reg}, {1'b1, e});
      @(negedge clk);
   endtask
   // hold, check the held state, release, wait for restart
   // partner reads these on the same falling edge, so update them after it has sampled
   task sync_pulse;
      sync_req <= 1'b1;
      repeat (40) @(negedge clk);
      chk({lo_i_reg, lo_q_reg, lo_phase_reg}, 4'b0011);
      clk_run <= 1'b1;
      sync_req <= 1'b0;
      for (n = 0; n < 100 && divider_run_reg !== 1'b1; n++) @(negedge clk);
      chk({lo_i_reg, lo_q_reg, lo_phase_reg}, 4'b1000);
   endtask
   initial
   begin
      #100000;
      err_total++;
      end_sim();
   end
   initial
   begin
      repeat (4) @(negedge clk);
      reset = 0;
      wr(8'h01, 8'hf1);
      rd(3'h0, 8'h2d, 8'h11);
      wr(8'h02, 8'h03);
      rd(3'h1, 8'h2d, 8'h03);
      rd(3'h0, 8'h2d, 8'h11);
      rd(3'h0, 8'h2c, 8'h00);
      wr(8'h08, 8'h04);
      rd(3'h3, 8'h2d, 8'h04);
      chk({chan_enable[3], chan_cos[31:24], chan_sin[31:24]}, 0);
      // two channels written at once with one code must match exactly
      wr(8'h05, 8'h14);
      chk({chan_cos[7:0], chan_sin[7:0]}, {chan_cos[23:16], chan_sin[23:16]});
      chk({chan_code[3:0], chan_sin[7:0]}, {4'h4, 8'h7f});
      for (int c = 0; c < 16; c++)
      begin
         wr(8'h04, 8'h10 | c[7:0]);
         rd(3'h2, 8'h2d, 8'h10 | c[7:0]);
         chk({chan_enable[2], chan_code[11:8]}, {1'b1, c[3:0]});
         if (c[1:0] == 2'h0)
            chk({chan_cos[23:16], chan_sin[23:16]}, tbl[c / 4]);
         // one step up: cos and sin of 22.5 degrees, scaled to 127
         if (c == 1)
            chk({chan_cos[23:16], chan_sin[23:16]}, 16'h7531);
      end
      sync_pulse();
      hi_i = 0;
      hi_q = 0;
      repeat (200)
      begin
         hi_i += lo_i_reg;
         hi_q += lo_q_reg;
         @(negedge clk);
      end
      chk(hi_i, 100);
      chk(hi_q, 100);
      wr(8'h04, 8'h18);
      for (n = 0; n < 60 && chan_code[11:8] !== 4'h8; n++) @(negedge clk);
      chk({chan_code[11:8], lo_phase_reg}, {4'h8, 2'h0});
      sync_pulse();
      // plain reset with the 4x clock running: no sync, so the divider
      // starts from its power-up count and the first step gives count 1
      reset = 1;
      repeat (4) @(negedge clk);
      reset = 0;
      rd(3'h2, 8'h2d, 8'h00);
      for (n = 0; n < 100 && divider_run_reg !== 1'b1; n++) @(negedge clk);
      chk({lo_i_reg, lo_q_reg, lo_phase_reg}, 4'b1101);
      end_sim();
   end
endmodule // tb_qlpd_phase_divider
